// file: rtl/async_serial_extension_control.v
// Function
// - auto-enabled carrier detect high holds channel 0 receiver in reset
// - carrier detect disable set lets receiver run regardless of pin
// - carrier detect level readable; rising edge sets carrier detect interrupt status
// - auto-enabled clear-to-send high forces channel 0 tx empty flag to zero
// - clear-to-send disable set ignores pin; level still readable in control B
// - unit clock bit uses generator or external clock directly as bit clock
// - otherwise divide generator or external clock by 16 or 64
// - fixed mode divides system clock by 10 or 30 then power of two
// - generator mode divides system clock by twice time constant plus four
// - break detect and send break work only while break enable set
// - all-zero framed-error oldest character sets break detect
// - break detect cleared by error reset write, reset, io stop, auto-enabled channel 0 carrier loss
// - send break with break enable holds transmit pin low
// - both extension registers reset to zero
// - tx empty clears on data write, sets when byte moves to shifter
`timescale 1ns/1ps
`include "async_ext_defs.vh"
module async_ext_chan #(
	parameter CH0 = 1
) (
	input wire clk,
	input wire rst_n,
	input wire [7:0] ext_wr,
	input wire ext_we,
	input wire [7:0] ctrl_b,
	input wire [15:0] tconst,
	input wire efr_zero_wr,
	input wire io_stop,
	input wire txd_we,
	input wire tx_load,
	input wire tx_serial,
	input wire rx_head_valid,
	input wire [7:0] rx_head,
	input wire rx_head_fe,
	input wire ext_clk,
	input wire dcd_active,
	input wire cts_block,
	output reg [7:0] ext,
	output reg txe,
	output reg bit_tick,
	output reg clk_out,
	output reg tx_pin,
	output reg rx_hold,
	output wire brk_set
);
	reg [15:0] gen_cnt;
	reg [6:0] ovs_cnt;
	reg ext_d;
	reg gen_tick;
	reg [15:0] next_limit;
	wire ss_ext = (ctrl_b[2:0] == `SS_EXT);
	wire [7:0] pre = ctrl_b[`B_PRESCALE] ? `PRE_DIV_HI : `PRE_DIV_LO;
	wire dcd_off = (CH0 != 0) && dcd_active && !ext[`B_DCD_DIS];
	wire [6:0] ovs = ctrl_b[`B_PRESCALE] ? `OVS_HI : `OVS_LO;
	// one source tick per full generator period, on the rising half
	wire src_tick = ss_ext ? (ext_clk && !ext_d) : (gen_tick && clk_out);
	assign brk_set = ext[`B_BRK_EN] && rx_head_valid && rx_head_fe &&
		(rx_head == 8'h00) && !ext[`B_BRK_DET];
	// next_limit is the half period of the generator clock in system clocks
	always @* begin
		next_limit = 16'h0000;
		if (ext[`B_GEN_MODE])
			next_limit = tconst + 16'h0002;
		else
			next_limit = ({8'h00, pre} << ctrl_b[2:0]) >> 1;
	end
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext <= `EXT_RESET;
			txe <= 1'b1;
			gen_cnt <= 16'h0000;
			ovs_cnt <= 7'h00;
			ext_d <= 1'b0;
			gen_tick <= 1'b0;
			bit_tick <= 1'b0;
			clk_out <= 1'b0;
			tx_pin <= 1'b1;
			rx_hold <= 1'b0;
		end else begin
			ext_d <= ext_clk;
			gen_tick <= 1'b0;
			if (gen_cnt + 16'h0001 >= next_limit) begin
				gen_cnt <= 16'h0000;
				gen_tick <= 1'b1;
				clk_out <= ~clk_out;
			end else begin
				gen_cnt <= gen_cnt + 16'h0001;
			end
			bit_tick <= 1'b0;
			if (src_tick) begin
				if (ext[`B_UNIT_CLK]) begin
					bit_tick <= 1'b1;
				end else if (ovs_cnt + 7'h01 >= ovs) begin
					ovs_cnt <= 7'h00;
					bit_tick <= 1'b1;
				end else begin
					ovs_cnt <= ovs_cnt + 7'h01;
				end
			end
			if (ext_we) begin
				ext[`B_DCD_DIS] <= (CH0 != 0) ? ext_wr[`B_DCD_DIS] : 1'b0;
				ext[`B_CTS_DIS] <= (CH0 != 0) ? ext_wr[`B_CTS_DIS] : 1'b0;
				ext[`B_UNIT_CLK] <= ext_wr[`B_UNIT_CLK];
				ext[`B_GEN_MODE] <= ext_wr[`B_GEN_MODE];
				ext[`B_BRK_EN] <= ext_wr[`B_BRK_EN];
				ext[`B_SEND_BRK] <= ext_wr[`B_SEND_BRK];
			end
			if (brk_set)
				ext[`B_BRK_DET] <= 1'b1;
			else if (efr_zero_wr || io_stop || dcd_off || !ext[`B_BRK_EN])
				ext[`B_BRK_DET] <= 1'b0;
			if (io_stop || tx_load)
				txe <= 1'b1;
			else if (txd_we)
				txe <= 1'b0;
			tx_pin <= (ext[`B_SEND_BRK] && ext[`B_BRK_EN]) ? 1'b0 : tx_serial;
			rx_hold <= dcd_off;
		end
	end
	wire unused = cts_block;
endmodule

module async_serial_extension_control (
	input wire I_MCLK,
	input wire I_RESETN,
	input wire [3:0] I_ADDR,
	input wire [7:0] I_WDATA,
	input wire I_WR,
	input wire I_RD,
	input wire I_IO_STOP,
	input wire I_CARRIER_DETECT_N,
	input wire I_CLEAR_TO_SEND_N,
	input wire I_CARRIER_FN_SEL,
	input wire I_CTS_FN_SEL,
	input wire I_SERIAL_CLOCK_PIN0,
	input wire I_SERIAL_CLOCK_PIN1,
	input wire [1:0] I_TX_LOAD,
	input wire [1:0] I_TX_SERIAL,
	input wire [1:0] I_RX_HEAD_VALID,
	input wire [7:0] I_RX_HEAD0,
	input wire [7:0] I_RX_HEAD1,
	input wire [1:0] I_RX_HEAD_FE,
	output reg [7:0] O_RDATA,
	output reg O_IRQ,
	output reg [1:0] O_SERIAL_TX_PIN,
	output reg [1:0] O_BIT_TICK,
	output reg [1:0] O_SERIAL_CLOCK_OUT,
	output reg [1:0] O_TX_REGISTER_EMPTY,
	output reg O_RX0_HOLD
);
	reg [2:0] dcd_sync;
	reg [2:0] cts_sync;
	reg [2:0] ck0_sync;
	reg [2:0] ck1_sync;
	reg dcd_lvl;
	reg cts_lvl;
	reg ck0_lvl;
	reg ck1_lvl;
	reg [7:0] ctrl_b0;
	reg [7:0] ctrl_b1;
	reg [15:0] tc0;
	reg [15:0] tc1;
	reg [7:0] ctrl_a0;
	reg [7:0] ctrl_a1;
	reg [3:0] irq_stat;
	reg [3:0] irq_mask;
	reg txe0_d;
	reg [3:0] next_stat;
	reg [7:0] next_rdata;
	wire [7:0] ext0;
	wire [7:0] ext1;
	wire txe0_raw;
	wire txe1;
	wire tick0;
	wire tick1;
	wire cko0;
	wire cko1;
	wire txp0;
	wire txp1;
	wire hold0;
	wire hold1;
	wire bset0;
	wire bset1;
	wire wr_ext0 = I_WR && (I_ADDR == `OFS_EXT_CH0);
	wire wr_ext1 = I_WR && (I_ADDR == `OFS_EXT_CH1);
	wire wr_a0 = I_WR && (I_ADDR == `OFS_CTRL_A0);
	wire wr_a1 = I_WR && (I_ADDR == `OFS_CTRL_A1);
	// register write decodes
	wire wr_b0 = I_WR && (I_ADDR == `OFS_CTRL_B0);
	wire wr_b1 = I_WR && (I_ADDR == `OFS_CTRL_B1);
	wire wr_tc0l = I_WR && (I_ADDR == `OFS_TC0_LO);
	wire wr_tc0h = I_WR && (I_ADDR == `OFS_TC0_HI);
	wire wr_tc1l = I_WR && (I_ADDR == `OFS_TC1_LO);
	wire wr_tc1h = I_WR && (I_ADDR == `OFS_TC1_HI);
	wire wr_mask = I_WR && (I_ADDR == `OFS_IRQ_MASK);
	wire wr_stat = I_WR && (I_ADDR == `OFS_IRQ_STAT);
	wire wr_txd0 = I_WR && (I_ADDR == `OFS_TXDATA0);
	wire wr_txd1 = I_WR && (I_ADDR == `OFS_TXDATA1);
	// writing zero to the error reset bit clears break detect
	wire efr0_clr = wr_a0 && !I_WDATA[`B_EFR];
	wire efr1_clr = wr_a1 && !I_WDATA[`B_EFR];
	wire dcd_act = I_CARRIER_FN_SEL && dcd_lvl;
	wire cts_blk = I_CTS_FN_SEL && cts_lvl && !ext0[`B_CTS_DIS];
	wire txe0 = txe0_raw && !cts_blk;
	wire dcd_rise = (dcd_sync[2:1] == 2'b01) && !dcd_lvl;
	// channel 0 carries the modem line auto-enables
	async_ext_chan #(
		.CH0(1)
	) chan0 (
		.clk(I_MCLK),
		.rst_n(I_RESETN),
		.ext_wr(I_WDATA),
		.ext_we(wr_ext0),
		.ctrl_b(ctrl_b0),
		.tconst(tc0),
		.efr_zero_wr(efr0_clr),
		.io_stop(I_IO_STOP),
		.txd_we(wr_txd0),
		.tx_load(I_TX_LOAD[0]),
		.tx_serial(I_TX_SERIAL[0]),
		.rx_head_valid(I_RX_HEAD_VALID[0]),
		.rx_head(I_RX_HEAD0),
		.rx_head_fe(I_RX_HEAD_FE[0]),
		.ext_clk(ck0_lvl),
		.dcd_active(dcd_act),
		.cts_block(cts_blk),
		.ext(ext0),
		.txe(txe0_raw),
		.bit_tick(tick0),
		.clk_out(cko0),
		.tx_pin(txp0),
		.rx_hold(hold0),
		.brk_set(bset0)
	);
	// channel 1 has no modem line gating
	async_ext_chan #(
		.CH0(0)
	) chan1 (
		.clk(I_MCLK),
		.rst_n(I_RESETN),
		.ext_wr(I_WDATA),
		.ext_we(wr_ext1),
		.ctrl_b(ctrl_b1),
		.tconst(tc1),
		.efr_zero_wr(efr1_clr),
		.io_stop(I_IO_STOP),
		.txd_we(wr_txd1),
		.tx_load(I_TX_LOAD[1]),
		.tx_serial(I_TX_SERIAL[1]),
		.rx_head_valid(I_RX_HEAD_VALID[1]),
		.rx_head(I_RX_HEAD1),
		.rx_head_fe(I_RX_HEAD_FE[1]),
		.ext_clk(ck1_lvl),
		.dcd_active(1'b0),
		.cts_block(1'b0),
		.ext(ext1),
		.txe(txe1),
		.bit_tick(tick1),
		.clk_out(cko1),
		.tx_pin(txp1),
		.rx_hold(hold1),
		.brk_set(bset1)
	);
	// status bits: the event sets, a written one clears, set wins
	always @* begin
		next_stat = irq_stat;
		if (wr_stat)
			next_stat = irq_stat & ~I_WDATA[3:0];
		next_stat[`IRQ_CARRIER_DETECT_N] = next_stat[`IRQ_CARRIER_DETECT_N] | dcd_rise;
		next_stat[`IRQ_BRK0] = next_stat[`IRQ_BRK0] | bset0;
		next_stat[`IRQ_BRK1] = next_stat[`IRQ_BRK1] | bset1;
		next_stat[`IRQ_TXE0] = next_stat[`IRQ_TXE0] | (txe0 && !txe0_d);
	end
	always @* begin
		next_rdata = 8'h00;
		case (I_ADDR)
			`OFS_EXT_CH0: next_rdata = ext0;
			`OFS_EXT_CH1: next_rdata = ext1;
			`OFS_CTRL_B0: next_rdata = {cts_lvl, ctrl_b0[6:0]};
			`OFS_CTRL_B1: next_rdata = {1'b0, ctrl_b1[6:0]};
			`OFS_TC0_LO: next_rdata = tc0[7:0];
			`OFS_TC0_HI: next_rdata = tc0[15:8];
			`OFS_TC1_LO: next_rdata = tc1[7:0];
			`OFS_TC1_HI: next_rdata = tc1[15:8];
			`OFS_CTRL_A0: next_rdata = ctrl_a0;
			`OFS_CTRL_A1: next_rdata = ctrl_a1;
			`OFS_STATUS0: next_rdata = {5'h00, dcd_lvl, txe0, hold0};
			`OFS_STATUS1: next_rdata = {6'h00, txe1, hold1};
			`OFS_IRQ_STAT: next_rdata = {4'h0, irq_stat};
			`OFS_IRQ_MASK: next_rdata = {4'h0, irq_mask};
			default: next_rdata = 8'h00;
		endcase
	end
	always @(posedge I_MCLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			dcd_sync <= 3'h7;
			cts_sync <= 3'h7;
			ck0_sync <= 3'h0;
			ck1_sync <= 3'h0;
			dcd_lvl <= 1'b1;
			cts_lvl <= 1'b1;
			ck0_lvl <= 1'b0;
			ck1_lvl <= 1'b0;
			ctrl_b0 <= 8'h07;
			ctrl_b1 <= 8'h07;
			tc0 <= 16'h0000;
			tc1 <= 16'h0000;
			ctrl_a0 <= 8'h00;
			ctrl_a1 <= 8'h00;
			irq_stat <= 4'h0;
			irq_mask <= 4'h0;
			txe0_d <= 1'b1;
			O_RDATA <= 8'h00;
			O_IRQ <= 1'b0;
			O_SERIAL_TX_PIN <= 2'h3;
			O_BIT_TICK <= 2'h0;
			O_SERIAL_CLOCK_OUT <= 2'h0;
			O_TX_REGISTER_EMPTY <= 2'h3;
			O_RX0_HOLD <= 1'b0;
		end else begin
			dcd_sync <= {dcd_sync[1:0], I_CARRIER_DETECT_N};
			cts_sync <= {cts_sync[1:0], I_CLEAR_TO_SEND_N};
			ck0_sync <= {ck0_sync[1:0], I_SERIAL_CLOCK_PIN0};
			ck1_sync <= {ck1_sync[1:0], I_SERIAL_CLOCK_PIN1};
			if (dcd_sync[2] == dcd_sync[1])
				dcd_lvl <= dcd_sync[2];
			if (cts_sync[2] == cts_sync[1])
				cts_lvl <= cts_sync[2];
			if (ck0_sync[2] == ck0_sync[1])
				ck0_lvl <= ck0_sync[2];
			if (ck1_sync[2] == ck1_sync[1])
				ck1_lvl <= ck1_sync[2];
			if (wr_b0)
				ctrl_b0 <= {1'b0, I_WDATA[6:0]};
			if (wr_b1)
				ctrl_b1 <= {1'b0, I_WDATA[6:0]};
			if (wr_tc0l)
				tc0[7:0] <= I_WDATA;
			if (wr_tc0h)
				tc0[15:8] <= I_WDATA;
			if (wr_tc1l)
				tc1[7:0] <= I_WDATA;
			if (wr_tc1h)
				tc1[15:8] <= I_WDATA;
			if (wr_a0)
				ctrl_a0 <= I_WDATA;
			if (wr_a1)
				ctrl_a1 <= I_WDATA;
			if (wr_mask)
				irq_mask <= I_WDATA[3:0];
			irq_stat <= next_stat;
			txe0_d <= txe0;
			O_RDATA <= I_RD ? next_rdata : 8'h00;
			O_IRQ <= |(next_stat & irq_mask);
			O_SERIAL_TX_PIN <= {txp1, txp0};
			O_BIT_TICK <= {tick1, tick0};
			O_SERIAL_CLOCK_OUT <= {cko1, cko0};
			O_TX_REGISTER_EMPTY <= {txe1, txe0};
			O_RX0_HOLD <= hold0;
		end
	end
endmodule

// file: rtl/async_ext_defs.vh
`ifndef ASYNC_EXT_DEFS_VH
`define ASYNC_EXT_DEFS_VH
`define ADDR_W 4
`define OFS_EXT_CH0 4'h0
`define OFS_EXT_CH1 4'h1
`define OFS_CTRL_B0 4'h2
`define OFS_CTRL_B1 4'h3
`define OFS_TC0_LO 4'h4
`define OFS_TC0_HI 4'h5
`define OFS_TC1_LO 4'h6
`define OFS_TC1_HI 4'h7
`define OFS_CTRL_A0 4'h8
`define OFS_CTRL_A1 4'h9
`define OFS_STATUS0 4'ha
`define OFS_STATUS1 4'hb
`define OFS_TXDATA0 4'hc
`define OFS_TXDATA1 4'hd
`define OFS_IRQ_STAT 4'he
`define OFS_IRQ_MASK 4'hf
`define EXT_RESET 8'h00
`define B_DCD_DIS 6
`define B_CTS_DIS 5
`define B_UNIT_CLK 4
`define B_GEN_MODE 3
`define B_BRK_EN 2
`define B_BRK_DET 1
`define B_SEND_BRK 0
`define B_PRESCALE 5
`define B_CTS_LVL 7
`define B_EFR 3
`define SS_EXT 3'h7
`define PRE_DIV_LO 8'h0a
`define PRE_DIV_HI 8'h1e
`define OVS_LO 7'h10
`define OVS_HI 7'h40
`define IRQ_CARRIER_DETECT_N 0
`define IRQ_BRK0 1
`define IRQ_BRK1 2
`define IRQ_TXE0 3
`endif

// file: tb/remote_serial_dev.sv
`timescale 1ns/1ps
module remote_serial_dev (
	input wire i_clk,
	input wire i_carrier_on,
	input wire i_cts_on,
	output reg o_carrier_detect_n,
	output reg o_clear_to_send_n
);
	// far side modem lines, negated high
	initial o_carrier_detect_n = 1'b0;
	initial o_clear_to_send_n = 1'b0;
	always @(posedge i_clk) begin
		o_carrier_detect_n <= ~i_carrier_on;
		o_clear_to_send_n <= ~i_cts_on;
	end
endmodule

// file: tb/async_ext_chk.sv
`timescale 1ns/1ps
`include "async_ext_defs.vh"
module async_ext_chk (
	input wire I_MCLK,
	input wire I_RESETN,
	input wire [3:0] I_ADDR,
	input wire [7:0] I_WDATA,
	input wire I_WR,
	input wire I_IO_STOP,
	input wire I_CARRIER_DETECT_N,
	input wire I_CLEAR_TO_SEND_N,
	input wire I_CARRIER_FN_SEL,
	input wire I_CTS_FN_SEL,
	input wire [1:0] I_TX_LOAD,
	input wire [1:0] I_TX_SERIAL,
	input wire [1:0] O_SERIAL_TX_PIN,
	input wire [1:0] O_TX_REGISTER_EMPTY,
	input wire O_RX0_HOLD
);
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RESETN);
	reg [7:0] sh;
	// shadow of the channel 0 extension register
	always @(posedge I_MCLK or negedge I_RESETN)
		if (!I_RESETN) sh <= 8'h00;
		else if (I_WR && I_ADDR == `OFS_EXT_CH0) sh <= I_WDATA;
	wire brk = sh[2] & sh[0];
	wire hold = I_CARRIER_FN_SEL & ~sh[6] & I_CARRIER_DETECT_N;
	wire gate = I_CTS_FN_SEL & ~sh[5] & I_CLEAR_TO_SEND_N;
	chk_tx_break: assert property (brk [*3] |-> !O_SERIAL_TX_PIN[0])
		else $error("tx pin not low in break");
	chk_tx_pass: assert property ((!brk) [*3] |-> O_SERIAL_TX_PIN[0] == $past(I_TX_SERIAL[0], 2))
		else $error("tx pin not following transmitter");
	chk_rx_hold: assert property (hold [*8] |-> O_RX0_HOLD)
		else $error("receiver not held");
	chk_rx_free: assert property ((!hold) [*8] |-> !O_RX0_HOLD)
		else $error("receiver held wrongly");
	chk_cts_gate: assert property (gate [*8] |-> !O_TX_REGISTER_EMPTY[0])
		else $error("tx empty not gated");
	chk_txe_stop: assert property (I_IO_STOP [*2] |-> O_TX_REGISTER_EMPTY[1])
		else $error("tx empty not set in stop");
	chk_txe_load: assert property (I_TX_LOAD[1] && !I_WR |-> ##[1:2] O_TX_REGISTER_EMPTY[1])
		else $error("tx empty not set on load");
	chk_txe_write: assert property (I_WR && I_ADDR == `OFS_TXDATA1 && !I_TX_LOAD[1] && !I_IO_STOP
		|-> ##2 !O_TX_REGISTER_EMPTY[1])
		else $error("tx empty not cleared on write");
endmodule
bind async_serial_extension_control async_ext_chk u_chk (.I_MCLK, .I_RESETN, .I_ADDR, .I_WDATA,
	.I_WR, .I_IO_STOP, .I_CARRIER_DETECT_N, .I_CLEAR_TO_SEND_N, .I_CARRIER_FN_SEL, .I_CTS_FN_SEL,
	.I_TX_LOAD, .I_TX_SERIAL, .O_SERIAL_TX_PIN, .O_TX_REGISTER_EMPTY, .O_RX0_HOLD);

// file: tb/tb_async_serial_extension_control.sv
`timescale 1ns/1ps
module tb_async_serial_extension_control;
	reg I_MCLK = 0, I_RESETN = 0, I_WR = 0, I_RD = 0, I_IO_STOP = 0;
	reg I_CARRIER_FN_SEL = 0, I_CTS_FN_SEL = 0, carrier_on = 1, cts_on = 1;
	reg [3:0] I_ADDR = 0;
	reg [7:0] I_WDATA = 0, I_RX_HEAD0 = 0;
	reg [1:0] I_TX_LOAD = 0, I_TX_SERIAL = 0, I_RX_HEAD_VALID = 0, I_RX_HEAD_FE = 0;
	wire [7:0] O_RDATA;
	wire O_IRQ, O_RX0_HOLD, dcd_n, cts_n;
	wire [1:0] O_SERIAL_TX_PIN, O_BIT_TICK, O_SERIAL_CLOCK_OUT, O_TX_REGISTER_EMPTY;
	int failures = 0, num_checks = 0, i;
	// write flag, address, data, expected read; break detect and ch1 bits 6,5 stay 0
	int regs[6][4] = '{'{0,0,0,0}, '{0,1,0,0}, '{1,0,8'h7f,8'h7d}, '{1,1,8'h7f,8'h1d},
		'{1,0,0,0}, '{1,1,0,0}};
	// control B, extension, clock period, bit tick period
	int clks[5][4] = '{'{8'h00,0,10,160}, '{8'h20,0,30,1920}, '{8'h01,0,20,320}, '{0,8'h08,6,96},
		'{8'h00,8'h10,10,10}};
	async_serial_extension_control u_async_serial_extension_control (.I_MCLK(I_MCLK),
		.I_RESETN(I_RESETN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
		.I_IO_STOP(I_IO_STOP), .I_CARRIER_DETECT_N(dcd_n), .I_CLEAR_TO_SEND_N(cts_n),
		.I_CARRIER_FN_SEL(I_CARRIER_FN_SEL), .I_CTS_FN_SEL(I_CTS_FN_SEL),
		.I_SERIAL_CLOCK_PIN0(1'b0), .I_SERIAL_CLOCK_PIN1(1'b0), .I_TX_LOAD(I_TX_LOAD),
		.I_TX_SERIAL(I_TX_SERIAL), .I_RX_HEAD_VALID(I_RX_HEAD_VALID), .I_RX_HEAD0(I_RX_HEAD0),
		.I_RX_HEAD1(8'h00), .I_RX_HEAD_FE(I_RX_HEAD_FE), .O_RDATA(O_RDATA), .O_IRQ(O_IRQ),
		.O_SERIAL_TX_PIN(O_SERIAL_TX_PIN), .O_BIT_TICK(O_BIT_TICK),
		.O_SERIAL_CLOCK_OUT(O_SERIAL_CLOCK_OUT), .O_TX_REGISTER_EMPTY(O_TX_REGISTER_EMPTY),
		.O_RX0_HOLD(O_RX0_HOLD));
	remote_serial_dev u_remote_serial_dev (.i_clk(I_MCLK), .i_carrier_on(carrier_on),
		.i_cts_on(cts_on), .o_carrier_detect_n(dcd_n), .o_clear_to_send_n(cts_n));
	initial forever #5 I_MCLK = ~I_MCLK;
	always @(posedge I_MCLK) I_TX_SERIAL <= ~I_TX_SERIAL;
	task close_out;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task wr(input [3:0] a, input [7:0] d);
		@(posedge I_MCLK);
		I_ADDR <= a;
		I_WDATA <= d;
		I_WR <= 1'b1;
		@(posedge I_MCLK);
		I_WR <= 1'b0;
	endtask
	task rc(input [3:0] a, input [7:0] e);
		@(posedge I_MCLK);
		I_ADDR <= a;
		I_RD <= 1'b1;
		@(posedge I_MCLK);
		I_RD <= 1'b0;
		#1 chk(O_RDATA, e);
	endtask
	task hd(input [7:0] v);
		@(posedge I_MCLK);
		I_RX_HEAD0 <= v;
		I_RX_HEAD_VALID <= 2'b01;
		I_RX_HEAD_FE <= 2'b01;
		@(posedge I_MCLK);
		I_RX_HEAD_VALID <= 2'b00;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge I_MCLK);
		#1;
	endtask
	// interval between two rising edges of the bit tick or the clock output
	task per(input bit sel, input int e);
		int n, k;
		logic p, s;
		n = 0;
		k = 0;
		p = 1'b1;
		while (k < 2) begin
			cyc(1);
			s = sel ? O_BIT_TICK[0] : O_SERIAL_CLOCK_OUT[0];
			n++;
			if (s && !p) begin
				k++;
				if (k == 1) n = 0;
			end
			p = s;
			if (n > 5000) begin
				failures++;
				close_out;
			end
		end
		chk(n, e);
	endtask
	initial begin
		repeat (4) @(posedge I_MCLK);
		I_RESETN <= 1'b1;
		for (i = 0; i < 6; i++) begin
			if (regs[i][0] != 0) wr(4'(regs[i][1]), 8'(regs[i][2]));
			rc(4'(regs[i][1]), 8'(regs[i][3]));
		end
		rc(4'h2, 8'h07);
		wr(4'h4, 8'h01);
		for (i = 0; i < 5; i++) begin
			wr(4'h2, 8'(clks[i][0]));
			wr(4'h0, 8'(clks[i][1]));
			per(0, clks[i][2]);
			per(1, clks[i][3]);
		end
		wr(4'h2, 8'h07);
		wr(4'h0, 8'h04);
		hd(8'h01);
		rc(4'h0, 8'h04);
		hd(8'h00);
		rc(4'h0, 8'h06);
		wr(4'h8, 8'h00);
		rc(4'h0, 8'h04);
		hd(8'h00);
		@(posedge I_MCLK) I_IO_STOP <= 1'b1;
		cyc(2);
		I_IO_STOP <= 1'b0;
		rc(4'h0, 8'h04);
		wr(4'h0, 8'h00);
		hd(8'h00);
		rc(4'h0, 8'h00);
		wr(4'h0, 8'h05);
		cyc(3);
		chk(O_SERIAL_TX_PIN[0], 0);
		wr(4'h0, 8'h04);
		wr(4'hd, 8'h55);
		cyc(1);
		chk(O_TX_REGISTER_EMPTY[1], 0);
		@(posedge I_MCLK) I_TX_LOAD <= 2'b10;
		@(posedge I_MCLK) I_TX_LOAD <= 2'b00;
		cyc(2);
		chk(O_TX_REGISTER_EMPTY[1], 1);
		I_CARRIER_FN_SEL <= 1'b1;
		carrier_on <= 1'b0;
		cyc(8);
		chk(O_RX0_HOLD, 1);
		chk(O_IRQ, 0);
		rc(4'ha, 8'h07);
		wr(4'hf, 8'h01);
		cyc(2);
		chk(O_IRQ, 1);
		wr(4'h0, 8'h40);
		wr(4'he, 8'h01);
		cyc(4);
		chk(O_RX0_HOLD, 0);
		chk(O_IRQ, 0);
		rc(4'ha, 8'h06);
		I_CTS_FN_SEL <= 1'b1;
		cts_on <= 1'b0;
		cyc(8);
		chk(O_TX_REGISTER_EMPTY[0], 0);
		rc(4'h2, 8'h87);
		wr(4'h0, 8'h20);
		cyc(4);
		chk(O_TX_REGISTER_EMPTY[0], 1);
		close_out;
	end
endmodule
